/* inc/ttl_defines.vh */
// Constants for the tape time locator: clock rates, scan timing, storage sizes.
`ifndef TTL_DEFINES_VH
`define TTL_DEFINES_VH
`define TTL_CORE_CLK_HZ      100000000
`define TTL_PHASE_CLK_HZ     1000000
`define TTL_PHASE_DIV        (`TTL_CORE_CLK_HZ / `TTL_PHASE_CLK_HZ)
`define TTL_SCAN_US          150
`define TTL_SCAN_TICKS       ((`TTL_SCAN_US * (`TTL_PHASE_CLK_HZ / 1000000)))
`define TTL_FRAME_HZ         60
`define TTL_DIGITS           4
`define TTL_DIGIT_TICKS      (`TTL_PHASE_CLK_HZ / (`TTL_FRAME_HZ * `TTL_DIGITS))
`define TTL_MIRROR_FACETS    8
`define TTL_SLOT_COUNT       9
`define TTL_TIME_RESET       16'h0000
`define TTL_SEG_RESET        7'h00
`define TTL_SEL_FIRST        4'h1
`endif

/* verification/tb_top.sv */
// Self-checking bench for the tape time locator and its transport
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // Segment patterns for digits 9 down to 0, digit 0 in the lowest seven bits
    localparam logic [69:0] SEG = {7'h6F, 7'h7F, 7'h07, 7'h7D, 7'h6D, 7'h66, 7'h4F, 7'h5B, 7'h06, 7'h3F};
    logic core_clk_in = 0, reset_in = 1, count_direction_select_in = 0;
    logic sensor_a_in, sensor_b_in;
    logic sw_locate_in = 0, sw_play_in = 0, sw_ffwd_in = 0, sw_rewind_in = 0, sw_stop_in = 0, sw_record_in = 0;
    logic key_down_in = 0, key_transfer_in = 0, key_store_in = 0, key_recall_in = 0, key_locate_reset_in = 0;
    logic [3:0] key_code_in = 4'h0;
    logic play_out, ffwd_out, rewind_out, stop_out, record_out, locating_out;
    logic [6:0] tape_seg_out, locate_seg_out;
    logic [3:0] digit_sel_out;
    logic signed [15:0] rises;
    int n_errors = 0, cmp_count = 0;
    // Short counts keep the run brief; expectations follow these values
    ttl_locator #(.SCAN_TICKS(4), .DIGIT_TICKS(2), .PULSES_PER_COUNT(2)) DUT (
        .core_clk_in(core_clk_in), .reset_in(reset_in), .sensor_a_in(sensor_a_in), .sensor_b_in(sensor_b_in),
        .count_direction_select_in(count_direction_select_in), .sw_locate_in(sw_locate_in),
        .sw_play_in(sw_play_in), .sw_ffwd_in(sw_ffwd_in), .sw_rewind_in(sw_rewind_in), .sw_stop_in(sw_stop_in),
        .sw_record_in(sw_record_in), .key_down_in(key_down_in), .key_code_in(key_code_in),
        .key_transfer_in(key_transfer_in), .key_store_in(key_store_in), .key_recall_in(key_recall_in),
        .key_locate_reset_in(key_locate_reset_in), .play_out(play_out), .ffwd_out(ffwd_out),
        .rewind_out(rewind_out), .stop_out(stop_out), .record_out(record_out), .locating_out(locating_out),
        .tape_seg_out(tape_seg_out), .locate_seg_out(locate_seg_out), .digit_sel_out(digit_sel_out));
    ttl_transport_model tp (.core_clk_in(core_clk_in), .fwd_in(play_out | ffwd_out), .rev_in(rewind_out),
        .sens_a_out(sensor_a_in), .sens_b_out(sensor_b_in), .rises_out(rises));
    initial forever #5 core_clk_in = ~core_clk_in;
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic stuck(input string what);
        n_errors++;
        $display("[FAIL] %0t ns: timed out on %s", $time, what);
        test_done();
    endtask
    task automatic wait_hi(ref logic s, input logic v, input int lim, input string what);
        for (int w = 0; s !== v; w++) begin
            if (w > lim) stuck(what);
            cyc(1);
        end
    endtask
    // Switch levels are only seen at a scan, so hold and release beyond one period
    task automatic press(ref logic s);
        s = 1'b1;
        cyc(600);
        s = 1'b0;
        cyc(600);
    endtask
    task automatic digit(input logic [3:0] d);
        key_code_in = d;
        press(key_down_in);
    endtask
    task automatic move_to(input int target);
        for (int w = 0; rises !== target; w++) begin
            if (w > 8000) stuck("tape motion");
            cyc(1);
        end
    endtask
    // Catch each digit 150 clocks after its select rises, then read both displays
    task automatic show(input logic [15:0] t, input logic [15:0] l);
        for (int k = 0; k < 4; k++) begin
            for (int w = 0; digit_sel_out === (4'h1 << k); w++) begin
                if (w > 900) stuck("digit scan");
                cyc(1);
            end
            for (int w = 0; digit_sel_out !== (4'h1 << k); w++) begin
                if (w > 900) stuck("digit scan");
                cyc(1);
            end
            cyc(150);
            chk(tape_seg_out, SEG[7*t[4*k+:4] +: 7], "tape digit");
            chk(locate_seg_out, SEG[7*l[4*k+:4] +: 7], "locate digit");
        end
    endtask
    task automatic t_reset();
        chk({play_out, ffwd_out, rewind_out, stop_out, record_out, locating_out}, 16'h0000, "commands");
        chk(digit_sel_out, 16'h0001, "digit select");
        show(16'h0000, 16'h0000);
        $display("reset test done");
    endtask
    task automatic t_keys();
        for (int i = 1; i < 5; i++) digit(4'(i));
        show(16'h0000, 16'h1234);
        press(key_transfer_in);
        show(16'h1234, 16'h1234);
        $display("keypad test done");
    endtask
    task automatic t_memory();
        press(key_store_in);
        digit(4'h1);
        digit(4'h5);
        press(key_store_in);
        digit(4'h9);
        press(key_locate_reset_in);
        show(16'h1234, 16'h0000);
        press(key_recall_in);
        digit(4'h1);
        show(16'h1234, 16'h1234);
        press(key_recall_in);
        digit(4'h9);
        show(16'h1234, 16'h2345);
        press(key_recall_in);
        digit(4'h0);
        show(16'h1234, 16'h0000);
        // First press opens recall, the second brings back the value shown before
        press(key_recall_in);
        press(key_recall_in);
        show(16'h1234, 16'h2345);
        $display("memory test done");
    endtask
    task automatic t_locate();
        press(key_locate_reset_in);
        press(key_transfer_in);
        digit(4'h2);
        sw_locate_in = 1'b1;
        wait_hi(locating_out, 1'b1, 900, "locate start");
        chk(ffwd_out, 16'h0001, "locate forward");
        wait_hi(locating_out, 1'b0, 6000, "locate end");
        chk({stop_out, ffwd_out}, 16'h0002, "locate stop");
        chk(rises, 16'h0004, "pulses used");
        sw_locate_in = 1'b0;
        cyc(600);
        show(16'h0002, 16'h0002);
        sw_locate_in = 1'b1;
        cyc(600);
        chk(locating_out, 16'h0000, "locate at target");
        sw_locate_in = 1'b0;
        cyc(600);
        $display("locate test done");
    endtask
    task automatic t_motion();
        sw_rewind_in = 1'b1;
        move_to(0);
        {sw_rewind_in, sw_stop_in} = 2'h1;
        cyc(600);
        chk(rewind_out, 16'h0000, "rewind halted");
        show(16'h0000, 16'h0002);
        count_direction_select_in = 1'b1;
        {sw_stop_in, sw_play_in} = 2'h1;
        move_to(4);
        {sw_play_in, sw_stop_in} = 2'h1;
        cyc(600);
        show(16'h9998, 16'h0002);
        {count_direction_select_in, sw_stop_in} = 2'h0;
        cyc(600);
        $display("motion test done");
    endtask
    task automatic t_switches();
        reset_in = 1'b1;
        cyc(3);
        reset_in = 1'b0;
        cyc(1);
        chk({stop_out, locating_out}, 16'h0000, "second reset");
        show(16'h0000, 16'h0000);
        for (int k = 0; k < 5; k++) begin
            {sw_play_in, sw_ffwd_in, sw_rewind_in, sw_record_in, sw_stop_in} = 5'h10 >> k;
            cyc(600);
            chk({play_out, ffwd_out, rewind_out, record_out, stop_out}, 16'h0010 >> k, "switch");
            {sw_play_in, sw_ffwd_in, sw_rewind_in, sw_record_in, sw_stop_in} = 5'h00;
            cyc(600);
        end
        $display("switch test done");
    endtask
    task automatic test_done();
        $display("compares %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Reset for ten clocks, then each scenario in turn
    initial begin
        cyc(10);
        reset_in = 1'b0;
        cyc(1);
        t_reset();
        t_keys();
        t_memory();
        t_locate();
        t_motion();
        t_switches();
        test_done();
    end
endmodule

/* verification/ttl_locator_chk.sv */
// Port assertions for the tape time locator
module ttl_locator_chk #(
    parameter int SCAN_TICKS  = 150,
    parameter int DIGIT_TICKS = 4166
) (
    input wire logic       core_clk_in, reset_in,
    input wire logic       sw_locate_in, sw_play_in, sw_ffwd_in,
    input wire logic       sw_rewind_in, sw_stop_in, sw_record_in,
    input wire logic       play_out, ffwd_out, rewind_out,
    input wire logic       stop_out, record_out, locating_out,
    input wire logic [6:0] tape_seg_out, locate_seg_out,
    input wire logic [3:0] digit_sel_out
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LAT   = SCAN_TICKS * 100 + 200;
    localparam int DWELL = (DIGIT_TICKS + 2) * 100;
    logic any_sw;
    int   sel_age_ff = 0;
    int   quiet_ff   = 0;
    int   stop_wait_ff = 0;
    assign any_sw = sw_play_in | sw_ffwd_in | sw_rewind_in | sw_record_in;
    // Ages of the digit select and of the switch levels; tick phase adds slack
    always @(posedge core_clk_in) begin
        sel_age_ff <= (reset_in || $changed(digit_sel_out)) ? 0 : sel_age_ff + 1;
        quiet_ff <= $changed({sw_locate_in, any_sw, sw_stop_in}) ? 0 : quiet_ff + 1;
        // A scan period is too long for a delay range, so the stop latency is counted here
        stop_wait_ff <= (reset_in || stop_out || !sw_stop_in) ? 0 : stop_wait_ff + 1;
    end
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);
    rst_vals_a: assert property (disable iff (1'b0)
        reset_in |=> {play_out, ffwd_out, rewind_out, stop_out, record_out, locating_out} == 6'h00
        && digit_sel_out == 4'h1 && {tape_seg_out, locate_seg_out} == 14'h0000) else $error("reset state wrong");
    sel_hot_a: assert property ($onehot(digit_sel_out)) else $error("digit select not one-hot");
    sel_hold_a: assert property ($changed(digit_sel_out) |=> $stable(digit_sel_out) [*8])
        else $error("digit dwell too short");
    frame_a: assert property (sel_age_ff <= DWELL) else $error("digit dwell too long");
    loc_go_a: assert property ($rose(locating_out) |-> (ffwd_out || rewind_out) && !stop_out)
        else $error("locate started without motion");
    loc_end_a: assert property ($fell(locating_out) && !any_sw |-> stop_out && !ffwd_out && !rewind_out)
        else $error("locate ended without stop");
    stop_ex_a: assert property (stop_out |-> !(play_out || ffwd_out || rewind_out || record_out))
        else $error("stop with motion");
    stop_resp_a: assert property (stop_wait_ff <= LAT)
        else $error("stop switch not followed");
    no_spont_a: assert property ($changed({play_out, record_out}) |-> quiet_ff <= LAT)
        else $error("command changed without input change");
    cover property ($rose(locating_out));
    cover property ($fell(locating_out) && stop_out);
    cover property ($rose(rewind_out));
endmodule
bind ttl_locator ttl_locator_chk #(.SCAN_TICKS(SCAN_TICKS), .DIGIT_TICKS(DIGIT_TICKS)) u_chk (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .sw_locate_in(sw_locate_in), .sw_play_in(sw_play_in),
    .sw_ffwd_in(sw_ffwd_in), .sw_rewind_in(sw_rewind_in), .sw_stop_in(sw_stop_in), .sw_record_in(sw_record_in),
    .play_out(play_out), .ffwd_out(ffwd_out), .rewind_out(rewind_out), .stop_out(stop_out),
    .record_out(record_out), .locating_out(locating_out), .tape_seg_out(tape_seg_out),
    .locate_seg_out(locate_seg_out), .digit_sel_out(digit_sel_out));

/* verification/ttl_transport_model.sv */
// Transport model: the idler mirror turning two sensor levels in quadrature
module ttl_transport_model #(parameter int STEP = 200) (
    // Clock
    input  wire logic          core_clk_in,
    // Motion commands from the locator
    input  wire logic          fwd_in,
    input  wire logic          rev_in,
    // Sensor levels and net count of A rises
    output logic               sens_a_out,
    output logic               sens_b_out,
    output logic signed [15:0] rises_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int         cnt = 0;
    logic [1:0] ph  = 2'h0;
    initial rises_out = 16'sh0000;
    // A leads B forward and lags on rewind; levels hold while the idler stands
    assign sens_a_out = ph[1] ^ ph[0];
    assign sens_b_out = ph[1];
    // A quarter phase per STEP clocks, slow enough for two 1 MHz samples each
    always @(posedge core_clk_in) begin
        if (fwd_in || rev_in) begin
            cnt <= (cnt == STEP - 1) ? 0 : cnt + 1;
            if (cnt == STEP - 1) begin
                ph <= fwd_in ? ph + 2'h1 : ph - 2'h1;
                if (fwd_in && ph == 2'h0) rises_out <= rises_out + 16'sh0001;
                if (!fwd_in && ph == 2'h3) rises_out <= rises_out - 16'sh0001;
            end
        end
    end
endmodule

/* verilog/ttl_locator.v */
// Tape time locator: time counting, keypad, displays, locate slots and transport command.
`include "ttl_defines.vh"
module ttl_locator #(
    parameter SCAN_TICKS  = `TTL_SCAN_TICKS,
    parameter DIGIT_TICKS = `TTL_DIGIT_TICKS,
    parameter PULSES_PER_COUNT = `TTL_MIRROR_FACETS
) (
    // Clock and reset
    input  wire       core_clk_in,
    input  wire       reset_in,
    // Motion sensors and option
    input  wire       sensor_a_in,
    input  wire       sensor_b_in,
    input  wire       count_direction_select_in,
    // Remote function switches
    input  wire       sw_locate_in,
    input  wire       sw_play_in,
    input  wire       sw_ffwd_in,
    input  wire       sw_rewind_in,
    input  wire       sw_stop_in,
    input  wire       sw_record_in,
    // Keypad
    input  wire       key_down_in,
    input  wire [3:0] key_code_in,
    input  wire       key_transfer_in,
    input  wire       key_store_in,
    input  wire       key_recall_in,
    input  wire       key_locate_reset_in,
    // Transport commands
    output reg        play_out,
    output reg        ffwd_out,
    output reg        rewind_out,
    output reg        stop_out,
    output reg        record_out,
    output reg        locating_out,
    // Display output port
    output reg  [6:0] tape_seg_out,
    output reg  [6:0] locate_seg_out,
    output reg  [3:0] digit_sel_out
);
    localparam MODE_IDLE   = 2'd0;
    localparam MODE_STORE  = 2'd1;
    localparam MODE_RECALL = 2'd2;
    localparam LOC_IDLE    = 2'd0;
    localparam LOC_FWD     = 2'd1;
    localparam LOC_REW     = 2'd2;
    localparam IN_W        = 11;
    localparam [31:0] PRE_TOP = PULSES_PER_COUNT - 1;

    reg  [6:0]      div_ff;
    reg             tick_ff;
    reg  [12:0]     scan_cnt_ff;
    reg  [12:0]     digit_cnt_ff;
    reg  [1:0]      digit_idx_ff;
    reg  [IN_W-1:0] samp_ff;
    reg  [3:0]      code_ff;
    reg  [15:0]     tape_ff;
    reg  [15:0]     locate_ff;
    reg  [15:0]     prev_locate_ff;
    reg  [3:0]      pre_ff;
    reg  [1:0]      mode_ff;
    reg  [1:0]      loc_ff;
    reg  [15:0]     slot_mem [1:`TTL_SLOT_COUNT];
    wire            count_pulse;
    wire            count_up;
    wire [IN_W-1:0] now_in;
    wire [IN_W-1:0] rise;
    wire            scan_now;
    wire            cmd_any;
    integer         k;

    // Seven-segment decode, segments g..a, lit high
    function [6:0] seg7;
        input [3:0] d;
        begin
            case (d)
                4'h0: seg7 = 7'h3f;
                4'h1: seg7 = 7'h06;
                4'h2: seg7 = 7'h5b;
                4'h3: seg7 = 7'h4f;
                4'h4: seg7 = 7'h66;
                4'h5: seg7 = 7'h6d;
                4'h6: seg7 = 7'h7d;
                4'h7: seg7 = 7'h07;
                4'h8: seg7 = 7'h7f;
                4'h9: seg7 = 7'h6f;
                default: seg7 = 7'h40;
            endcase
        end
    endfunction

    // Four-digit BCD step up or down, wrapping at 9999 and 0000
    function [15:0] bcd_step;
        input [15:0] v;
        input        up;
        integer      i;
        reg          carry;
        reg   [3:0]  d;
        begin
            bcd_step = v;
            carry    = 1'b1;
            for (i = 0; i < 4; i = i + 1) begin
                d = v[i*4 +: 4];
                if (carry) begin
                    if (up) begin
                        if (d == 4'h9) d = 4'h0;
                        else begin
                            d     = d + 4'h1;
                            carry = 1'b0;
                        end
                    end else begin
                        if (d == 4'h0) d = 4'h9;
                        else begin
                            d     = d - 4'h1;
                            carry = 1'b0;
                        end
                    end
                end
                bcd_step[i*4 +: 4] = d;
            end
        end
    endfunction

    // Switch levels are sampled as static states; only the motion path bypasses this
    assign now_in   = {sw_locate_in, sw_play_in, sw_ffwd_in, sw_rewind_in, sw_stop_in, sw_record_in,
                       key_transfer_in, key_store_in, key_recall_in, key_locate_reset_in, key_down_in};
    assign rise     = now_in & ~samp_ff;
    assign scan_now = tick_ff && (scan_cnt_ff == SCAN_TICKS - 1);
    // Any held transport switch outranks a locate request
    assign cmd_any  = sw_play_in | sw_ffwd_in | sw_rewind_in | sw_stop_in | sw_record_in;

    ttl_motion_decoder u_motion (
        .core_clk_in               (core_clk_in),
        .reset_in                  (reset_in),
        .tick_in                   (tick_ff),
        .sensor_a_in               (sensor_a_in),
        .sensor_b_in               (sensor_b_in),
        .count_direction_select_in (count_direction_select_in),
        .count_pulse_out           (count_pulse),
        .count_up_out              (count_up)
    );

    // 1 MHz timing enable divided from the core clock
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            div_ff  <= 7'd0;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (div_ff == `TTL_PHASE_DIV - 1);
            div_ff  <= (div_ff == `TTL_PHASE_DIV - 1) ? 7'd0 : div_ff + 7'd1;
        end
    end

    // Display scan: digit select walks four positions, both displays in step
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            digit_cnt_ff   <= 13'd0;
            digit_idx_ff   <= 2'd0;
            digit_sel_out  <= `TTL_SEL_FIRST;
            tape_seg_out   <= `TTL_SEG_RESET;
            locate_seg_out <= `TTL_SEG_RESET;
        end else if (tick_ff) begin
            tape_seg_out   <= seg7(tape_ff[digit_idx_ff*4 +: 4]);
            locate_seg_out <= seg7(locate_ff[digit_idx_ff*4 +: 4]);
            digit_sel_out  <= 4'h1 << digit_idx_ff;
            if (digit_cnt_ff == DIGIT_TICKS - 1) begin
                digit_cnt_ff <= 13'd0;
                digit_idx_ff <= digit_idx_ff + 2'd1;
            end else begin
                digit_cnt_ff <= digit_cnt_ff + 13'd1;
            end
        end
    end

    // Control: input scan, keypad, locate run and tape time accumulation
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            scan_cnt_ff    <= 13'd0;
            samp_ff        <= {IN_W{1'b0}};
            code_ff        <= 4'h0;
            tape_ff        <= `TTL_TIME_RESET;
            locate_ff      <= `TTL_TIME_RESET;
            prev_locate_ff <= `TTL_TIME_RESET;
            pre_ff         <= 4'h0;
            mode_ff        <= MODE_IDLE;
            loc_ff         <= LOC_IDLE;
            play_out       <= 1'b0;
            ffwd_out       <= 1'b0;
            rewind_out     <= 1'b0;
            stop_out       <= 1'b0;
            record_out     <= 1'b0;
            locating_out   <= 1'b0;
            for (k = 1; k <= `TTL_SLOT_COUNT; k = k + 1) begin
                slot_mem[k] <= `TTL_TIME_RESET;
            end
        end else begin
            if (tick_ff) begin
                scan_cnt_ff <= (scan_cnt_ff == SCAN_TICKS - 1) ? 13'd0 : scan_cnt_ff + 13'd1;
            end
            // Motion pulses, prescaled so direction reversals stay symmetric
            if (count_pulse) begin
                if (count_up) begin
                    if (pre_ff == PULSES_PER_COUNT - 1) begin
                        pre_ff  <= 4'h0;
                        tape_ff <= bcd_step(tape_ff, 1'b1);
                    end else pre_ff <= pre_ff + 4'h1;
                end else begin
                    if (pre_ff == 4'h0) begin
                        pre_ff  <= PRE_TOP[3:0];
                        tape_ff <= bcd_step(tape_ff, 1'b0);
                    end else pre_ff <= pre_ff - 4'h1;
                end
            end
            // Equality checked every enable, not every scan, to avoid overshoot
            if (tick_ff && loc_ff != LOC_IDLE && tape_ff == locate_ff) begin
                loc_ff       <= LOC_IDLE;
                locating_out <= 1'b0;
                ffwd_out     <= 1'b0;
                rewind_out   <= 1'b0;
                stop_out     <= 1'b1;
            end
            // Act only when the sampled switch state or key code differs from the last one
            if (scan_now && (now_in != samp_ff || key_code_in != code_ff)) begin
                samp_ff  <= now_in;
                code_ff  <= key_code_in;
                play_out <= sw_play_in;
                record_out <= sw_record_in;
                // Remote stop has no standby line, so it only halts
                stop_out <= sw_stop_in;
                if (sw_play_in || sw_ffwd_in || sw_rewind_in || sw_stop_in || sw_record_in) begin
                    loc_ff       <= LOC_IDLE;
                    locating_out <= 1'b0;
                    ffwd_out     <= sw_ffwd_in;
                    rewind_out   <= sw_rewind_in;
                end else if (loc_ff == LOC_IDLE) begin
                    ffwd_out   <= 1'b0;
                    rewind_out <= 1'b0;
                end
                if (rise[10] && tape_ff != locate_ff && !cmd_any) begin
                    locating_out <= 1'b1;
                    loc_ff       <= (tape_ff < locate_ff) ? LOC_FWD : LOC_REW;
                    ffwd_out     <= (tape_ff < locate_ff);
                    rewind_out   <= (tape_ff > locate_ff);
                    stop_out     <= 1'b0;
                end
                if (rise[4]) begin
                    tape_ff <= locate_ff;
                end
                if (rise[1]) begin
                    locate_ff <= `TTL_TIME_RESET;
                    mode_ff   <= MODE_IDLE;
                end
                case (mode_ff)
                    MODE_IDLE: begin
                        if (rise[3]) mode_ff <= MODE_STORE;
                        else if (rise[2]) mode_ff <= MODE_RECALL;
                        else if (rise[0] && key_code_in <= 4'h9) begin
                            locate_ff <= {locate_ff[11:0], key_code_in};
                        end
                    end
                    MODE_STORE: begin
                        if (rise[0]) begin
                            if (key_code_in >= 4'h1 && key_code_in <= 4'h9) begin
                                slot_mem[key_code_in] <= locate_ff;
                            end
                            mode_ff <= MODE_IDLE;
                        end
                    end
                    MODE_RECALL: begin
                        if (rise[2]) begin
                            // Second recall brings back the value shown before
                            locate_ff <= prev_locate_ff;
                            mode_ff   <= MODE_IDLE;
                        end else if (rise[0]) begin
                            prev_locate_ff <= locate_ff;
                            if (key_code_in == 4'h0) locate_ff <= `TTL_TIME_RESET;
                            else if (key_code_in <= 4'h9) locate_ff <= slot_mem[key_code_in];
                            mode_ff <= MODE_IDLE;
                        end
                    end
                    default: mode_ff <= MODE_IDLE;
                endcase
            end
        end
    end
endmodule

/* verilog/ttl_motion_decoder.v */
// Squares the two optical sensor levels into a count pulse and a direction.
module ttl_motion_decoder (
    // Clock, reset and 1 MHz timing enable
    input  wire       core_clk_in,
    input  wire       reset_in,
    input  wire       tick_in,
    // Optical sensors and direction sense option
    input  wire       sensor_a_in,
    input  wire       sensor_b_in,
    input  wire       count_direction_select_in,
    // Decoded motion
    output reg        count_pulse_out,
    output reg        count_up_out
);
    reg a_prev_ff;

    // One pulse per rising edge of sensor A; sensor B phase gives direction
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            // Start as if A were high: a sensor already high at reset must not count as an edge
            a_prev_ff       <= 1'b1;
            count_pulse_out <= 1'b0;
            count_up_out    <= 1'b1;
        end else begin
            count_pulse_out <= 1'b0;
            if (tick_in) begin
                a_prev_ff <= sensor_a_in;
                if (sensor_a_in && !a_prev_ff) begin
                    count_pulse_out <= 1'b1;
                    count_up_out    <= ~sensor_b_in ^ count_direction_select_in;
                end
            end
        end
    end
endmodule
